//--- circ_addr_ctrl.sv
// Circular buffer address control with AXI4-Lite register access
`timescale 1ns/1ps
`default_nettype none
`include "circ_regs.svh"

module circ_addr_ctrl (
    input  wire logic               aclk,
    input  wire logic               aresetn,
    input  wire logic [11:0]        s_axi_awaddr,
    input  wire logic               s_axi_awvalid,
    output logic                    s_axi_awready,
    input  wire logic [31:0]        s_axi_wdata,
    input  wire logic [3:0]         s_axi_wstrb,
    input  wire logic               s_axi_wvalid,
    output logic                    s_axi_wready,
    output logic [1:0]              s_axi_bresp,
    output logic                    s_axi_bvalid,
    input  wire logic               s_axi_bready,
    input  wire logic [11:0]        s_axi_araddr,
    input  wire logic               s_axi_arvalid,
    output logic                    s_axi_arready,
    output logic [31:0]             s_axi_rdata,
    output logic [1:0]              s_axi_rresp,
    output logic                    s_axi_rvalid,
    input  wire logic               s_axi_rready,
    input  wire circ_pkg::agu_req_t x_rd_req,
    output circ_pkg::agu_rsp_t      x_rd_rsp,
    input  wire circ_pkg::agu_req_t x_wr_req,
    output circ_pkg::agu_rsp_t      x_wr_rsp,
    input  wire circ_pkg::agu_req_t y_req,
    output circ_pkg::agu_rsp_t      y_rsp
);

    // ************************************************************
    // Register state
    // ************************************************************
    logic [15:0] ctrl_q;
    logic [15:0] ctrl_d;
    logic [15:0] bound_q [4];
    logic [15:0] bound_d [4];
    logic [2:0]  wrap_seen_q;
    logic [2:0]  wrap_seen_d;
    logic        x_active;
    logic        y_active;
    logic        x_rd_en;
    logic        x_wr_en;
    logic        y_en;

    // ************************************************************
    // Write channel
    // ************************************************************
    logic [11:0] aw_q;
    logic [11:0] aw_d;
    logic        aw_held_q;
    logic        aw_held_d;
    logic [31:0] w_q;
    logic [31:0] w_d;
    logic [3:0]  ws_q;
    logic [3:0]  ws_d;
    logic        w_held_q;
    logic        w_held_d;
    logic        bvalid_q;
    logic        bvalid_d;
    logic [1:0]  bresp_q;
    logic [1:0]  bresp_d;
    logic        do_write;
    logic        wr_hit;
    logic [15:0] wmask;
    logic [15:0] wval;

    assign s_axi_awready = !aw_held_q && !bvalid_q;
    assign s_axi_wready  = !w_held_q && !bvalid_q;
    assign s_axi_bvalid  = bvalid_q;
    assign s_axi_bresp   = bresp_q;

    always_comb
    begin
        aw_d      = aw_q;
        aw_held_d = aw_held_q;
        w_d       = w_q;
        ws_d      = ws_q;
        w_held_d  = w_held_q;
        bvalid_d  = bvalid_q;
        bresp_d   = bresp_q;
        if (s_axi_awvalid && s_axi_awready)
        begin
            aw_d      = s_axi_awaddr;
            aw_held_d = 1'b1;
        end
        if (s_axi_wvalid && s_axi_wready)
        begin
            w_d      = s_axi_wdata;
            ws_d     = s_axi_wstrb;
            w_held_d = 1'b1;
        end
        do_write = aw_held_q && w_held_q;
        wmask    = {{8{ws_q[1]}}, {8{ws_q[0]}}};
        wval     = w_q[15:0];
        wr_hit   = (aw_q[1:0] == 2'h0) && (aw_q <= `CIRC_STATUS_OFFSET);
        if (do_write)
        begin
            aw_held_d = 1'b0;
            w_held_d  = 1'b0;
            bvalid_d  = 1'b1;
            // Unmapped writes answer SLVERR and store nothing
            bresp_d   = wr_hit ? 2'h0 : 2'h2;
        end
        else if (bvalid_q && s_axi_bready)
        begin
            bvalid_d = 1'b0;
        end
    end

    // ************************************************************
    // Control and boundary registers
    // ************************************************************
    always_comb
    begin
        ctrl_d      = ctrl_q;
        bound_d     = bound_q;
        wrap_seen_d = wrap_seen_q;
        if (do_write)
        begin
            case (aw_q)
                `CIRC_CTRL_OFFSET:    ctrl_d = (ctrl_q & ~wmask) | (wval & wmask);
                `CIRC_X_START_OFFSET: bound_d[0] = (bound_q[0] & ~wmask) | (wval & wmask);
                `CIRC_X_END_OFFSET:   bound_d[1] = (bound_q[1] & ~wmask) | (wval & wmask);
                `CIRC_Y_START_OFFSET: bound_d[2] = (bound_q[2] & ~wmask) | (wval & wmask);
                `CIRC_Y_END_OFFSET:   bound_d[3] = (bound_q[3] & ~wmask) | (wval & wmask);
                // Write one to clear, a wrap in the same cycle wins
                `CIRC_STATUS_OFFSET:  wrap_seen_d = wrap_seen_q & ~(wval[2:0] & wmask[2:0]);
                default:              ctrl_d = ctrl_q;
            endcase
        end
        wrap_seen_d = wrap_seen_d | {y_rsp.wrapped, x_wr_rsp.wrapped, x_rd_rsp.wrapped};
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            ctrl_q      <= `CIRC_CTRL_RESET;
            bound_q     <= '{default: `CIRC_ADDR_RESET};
            wrap_seen_q <= 3'h0;
            aw_q        <= 12'h000;
            aw_held_q   <= 1'b0;
            w_q         <= 32'h00000000;
            ws_q        <= 4'h0;
            w_held_q    <= 1'b0;
            bvalid_q    <= 1'b0;
            bresp_q     <= 2'h0;
        end
        else
        begin
            ctrl_q      <= ctrl_d;
            bound_q     <= bound_d;
            wrap_seen_q <= wrap_seen_d;
            aw_q        <= aw_d;
            aw_held_q   <= aw_held_d;
            w_q         <= w_d;
            ws_q        <= ws_d;
            w_held_q    <= w_held_d;
            bvalid_q    <= bvalid_d;
            bresp_q     <= bresp_d;
        end
    end

    // ************************************************************
    // Read channel
    // ************************************************************
    logic        rvalid_q;
    logic        rvalid_d;
    logic [31:0] rdata_q;
    logic [31:0] rdata_d;
    logic [1:0]  rresp_q;
    logic [1:0]  rresp_d;

    assign s_axi_arready = !rvalid_q;
    assign s_axi_rvalid  = rvalid_q;
    assign s_axi_rdata   = rdata_q;
    assign s_axi_rresp   = rresp_q;

    always_comb
    begin
        rvalid_d = rvalid_q;
        rdata_d  = rdata_q;
        rresp_d  = rresp_q;
        if (s_axi_arvalid && s_axi_arready)
        begin
            rvalid_d = 1'b1;
            rresp_d  = 2'h0;
            case (s_axi_araddr)
                `CIRC_CTRL_OFFSET:    rdata_d = {16'h0000, ctrl_q};
                `CIRC_X_START_OFFSET: rdata_d = {16'h0000, bound_q[0]};
                `CIRC_X_END_OFFSET:   rdata_d = {16'h0000, bound_q[1]};
                `CIRC_Y_START_OFFSET: rdata_d = {16'h0000, bound_q[2]};
                `CIRC_Y_END_OFFSET:   rdata_d = {16'h0000, bound_q[3]};
                `CIRC_STATUS_OFFSET:  rdata_d = {27'h0000000, y_active, x_active, wrap_seen_q};
                default:
                begin
                    rdata_d = 32'h00000000;
                    rresp_d = 2'h2;
                end
            endcase
        end
        else if (rvalid_q && s_axi_rready)
        begin
            rvalid_d = 1'b0;
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            rvalid_q <= 1'b0;
            rdata_q  <= 32'h00000000;
            rresp_q  <= 2'h0;
        end
        else
        begin
            rvalid_q <= rvalid_d;
            rdata_q  <= rdata_d;
            rresp_q  <= rresp_d;
        end
    end

    // ************************************************************
    // Mode decode and address generators
    // ************************************************************
    always_comb
    begin
        x_active = ctrl_q[`CIRC_X_EN_BIT] && (ctrl_q[`CIRC_X_SEL_LSB +: 4] != `CIRC_SEL_OFF);
        y_active = ctrl_q[`CIRC_Y_EN_BIT] && (ctrl_q[`CIRC_Y_SEL_LSB +: 4] != `CIRC_SEL_OFF);
        x_rd_en  = x_active && (x_rd_req.reg_sel == ctrl_q[`CIRC_X_SEL_LSB +: 4]);
        x_wr_en  = x_active && (x_wr_req.reg_sel == ctrl_q[`CIRC_X_SEL_LSB +: 4]);
        y_en     = y_active && (y_req.reg_sel == ctrl_q[`CIRC_Y_SEL_LSB +: 4]);
    end

    circ_wrap_unit #(.WORD_ONLY(1'b0)) x_rd_unit (
        .enable     (x_rd_en),
        .start_addr (bound_q[0]),
        .end_addr   (bound_q[1]),
        .req        (x_rd_req),
        .rsp        (x_rd_rsp)
    );

    circ_wrap_unit #(.WORD_ONLY(1'b0)) x_wr_unit (
        .enable     (x_wr_en),
        .start_addr (bound_q[0]),
        .end_addr   (bound_q[1]),
        .req        (x_wr_req),
        .rsp        (x_wr_rsp)
    );

    circ_wrap_unit #(.WORD_ONLY(1'b1)) y_unit (
        .enable     (y_en),
        .start_addr (bound_q[2]),
        .end_addr   (bound_q[3]),
        .req        (y_req),
        .rsp        (y_rsp)
    );

    // ************************************************************
    // Checks
    // ************************************************************
    AST_X_OFF_NO_WRAP: assert property (@(posedge aclk) disable iff (!aresetn)
        (ctrl_q[3:0] == 4'hF) |-> !x_rd_rsp.wrapped && !x_wr_rsp.wrapped)
        else $error("X wrapped while select is 15");
    AST_Y_OFF_NO_WRAP: assert property (@(posedge aclk) disable iff (!aresetn)
        (ctrl_q[7:4] == 4'hF) |-> !y_rsp.wrapped)
        else $error("Y wrapped while select is 15");
    AST_X_EN_BIT: assert property (@(posedge aclk) disable iff (!aresetn)
        !ctrl_q[15] |-> !x_rd_rsp.wrapped && !x_wr_rsp.wrapped)
        else $error("X wrapped with enable clear");
    AST_Y_EN_BIT: assert property (@(posedge aclk) disable iff (!aresetn)
        !ctrl_q[14] |-> !y_rsp.wrapped)
        else $error("Y wrapped with enable clear");
    AST_UP_WRAP: assert property (@(posedge aclk) disable iff (!aresetn)
        x_rd_rsp.wrapped && !x_rd_req.decrement |-> x_rd_rsp.next_addr == bound_q[0])
        else $error("Up wrap did not load start");
    AST_DOWN_WRAP: assert property (@(posedge aclk) disable iff (!aresetn)
        x_wr_rsp.wrapped && x_wr_req.decrement |-> x_wr_rsp.next_addr == bound_q[1])
        else $error("Down wrap did not load end");
    AST_Y_EVEN: assert property (@(posedge aclk) disable iff (!aresetn)
        y_req.valid |-> !y_rsp.next_addr[0])
        else $error("Y address has low bit set");
    AST_BOUND_LOAD: assert property (@(posedge aclk) disable iff (!aresetn)
        do_write && aw_q == `CIRC_X_START_OFFSET && ws_q == 4'hF |=> bound_q[0] == $past(w_q[15:0]))
        else $error("X start not loaded");
    AST_STICKY: assert property (@(posedge aclk) disable iff (!aresetn)
        y_rsp.wrapped |=> wrap_seen_q[2])
        else $error("Y wrap not recorded");

endmodule : circ_addr_ctrl

`default_nettype wire

//--- circ_regs.svh
// Register offsets, field positions and reset values of the circular addressing block
`ifndef CIRC_REGS_SVH
`define CIRC_REGS_SVH

`define CIRC_CTRL_OFFSET      12'h000
`define CIRC_X_START_OFFSET   12'h004
`define CIRC_X_END_OFFSET     12'h008
`define CIRC_Y_START_OFFSET   12'h00C
`define CIRC_Y_END_OFFSET     12'h010
`define CIRC_STATUS_OFFSET    12'h014

`define CIRC_X_SEL_LSB        0
`define CIRC_Y_SEL_LSB        4
`define CIRC_Y_EN_BIT         14
`define CIRC_X_EN_BIT         15
`define CIRC_SEL_OFF          4'hF

`define CIRC_CTRL_RESET       16'h00FF
`define CIRC_ADDR_RESET       16'h0000

`endif

//--- circ_pkg.sv
// Types shared by the circular addressing block
`default_nettype none

package circ_pkg;

    typedef struct packed {
        logic        valid;
        logic [3:0]  reg_sel;
        logic [15:0] cur_addr;
        logic        decrement;
        logic [15:0] step;
    } agu_req_t;

    typedef struct packed {
        logic [15:0] next_addr;
        logic        wrapped;
    } agu_rsp_t;

    typedef enum logic [1:0] {
        SPACE_X_READ,
        SPACE_X_WRITE,
        SPACE_Y
    } space_t;

endpackage : circ_pkg

`default_nettype wire

//--- circ_wrap_unit.sv
// One modulo address generator: boundary compare and wrap
`timescale 1ns/1ps
`default_nettype none

module circ_wrap_unit #(
    parameter bit WORD_ONLY = 1'b0
) (
    input  wire logic               enable,
    input  wire logic [15:0]        start_addr,
    input  wire logic [15:0]        end_addr,
    input  wire circ_pkg::agu_req_t req,
    output circ_pkg::agu_rsp_t      rsp
);

    logic [16:0] raw_sum;
    logic [15:0] lin_addr;
    logic [15:0] lo_bound;
    logic [15:0] hi_bound;
    logic [15:0] cur_addr;
    logic        hit;

    always_comb
    begin
        cur_addr = WORD_ONLY ? {req.cur_addr[15:1], 1'b0} : req.cur_addr;
        lo_bound = WORD_ONLY ? {start_addr[15:1], 1'b0} : start_addr;
        hi_bound = WORD_ONLY ? {end_addr[15:1], 1'b0} : end_addr;
        if (req.decrement)
            raw_sum = {1'b0, cur_addr} - {1'b0, req.step};
        else
            raw_sum = {1'b0, cur_addr} + {1'b0, req.step};
        lin_addr = WORD_ONLY ? {raw_sum[15:1], 1'b0} : raw_sum[15:0];
        hit = enable && req.valid && (req.decrement
              ? (raw_sum[16] || lin_addr < lo_bound)
              : (raw_sum[16] || lin_addr > hi_bound));
        rsp.wrapped = hit;
        if (hit)
            rsp.next_addr = req.decrement ? hi_bound : lo_bound;
        else
            rsp.next_addr = lin_addr;
    end

endmodule : circ_wrap_unit

`default_nettype wire

//--- agu_core_model.sv
// Behavioural model of the core address generators
`timescale 1ns/1ps
`default_nettype none

module agu_core_model (
    input  wire logic          aclk,
    output circ_pkg::agu_req_t x_rd_req,
    output circ_pkg::agu_req_t x_wr_req,
    output circ_pkg::agu_req_t y_req
);
    // ************************************************
    // Request drive
    // ************************************************
    initial
    begin
        x_rd_req = '0;
        x_wr_req = '0;
        y_req    = '0;
    end

    // caller picks register, direction
    // One generator active per step so a stray wrap elsewhere stays visible
    task automatic step(input int sp, input logic [3:0] sel, input logic [15:0] cur,
                        input logic dec, input logic [15:0] stp);
        circ_pkg::agu_req_t r;
        r = {1'b1, sel, cur, dec, stp};
        @(posedge aclk);
        x_rd_req <= (sp == 0) ? r : '0;
        x_wr_req <= (sp == 1) ? r : '0;
        y_req    <= (sp == 2) ? r : '0;
        @(negedge aclk);
    endtask : step
endmodule : agu_core_model

`default_nettype wire

//--- tb_circ_addr_ctrl.sv
// Self-checking bench for the circular addressing block
`timescale 1ns/1ps
`default_nettype none
`include "circ_regs.svh"

module tb_circ_addr_ctrl;
    logic               aclk, aresetn, awvalid, wvalid, bvalid, bready, arvalid, rvalid, rready;
    logic               awready, wready, arready;
    logic [11:0]        awaddr, araddr;
    logic [31:0]        wdata, rdata, rd;
    logic [3:0]         wstrb;
    logic [1:0]         bresp, rresp, rs;
    circ_pkg::agu_req_t x_rd_req, x_wr_req, y_req;
    circ_pkg::agu_rsp_t x_rd_rsp, x_wr_rsp, y_rsp;
    int                 n_fail, total_checks;

    circ_addr_ctrl u_circ_addr_ctrl (
        .aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .x_rd_req(x_rd_req), .x_rd_rsp(x_rd_rsp), .x_wr_req(x_wr_req), .x_wr_rsp(x_wr_rsp),
        .y_req(y_req), .y_rsp(y_rsp)
    );
    agu_core_model u_agu_core_model (.aclk(aclk), .x_rd_req(x_rd_req), .x_wr_req(x_wr_req), .y_req(y_req));

    // ************************************************
    // Helpers
    // ************************************************
    initial
    begin
        aclk = 1'b0;
        forever #5 aclk = ~aclk;
    end

    task automatic report_and_stop;
        $display("Checks %0d, mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : report_and_stop

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        total_checks++;
        if (got !== exp)
        begin
            n_fail++;
            $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask : chk

    task automatic timeout_hit;
        n_fail++;
        $display("Error at %0t: handshake timeout", $time);
        report_and_stop();
    endtask : timeout_hit

    // Handshakes judged at the rising edge, released right after it
    task automatic axi_wr(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
        int i;
        r = 2'h3;
        @(posedge aclk);
        awaddr  <= a;
        wdata   <= d;
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        for (i = 0; i < 50; i++)
        begin
            @(posedge aclk);
            if (awvalid && awready)
                awvalid <= 1'b0;
            if (wvalid && wready)
                wvalid <= 1'b0;
            if (bvalid && bready)
            begin
                r = bresp;
                bready <= 1'b0;
                return;
            end
        end
        timeout_hit();
    endtask : axi_wr

    task automatic axi_rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
        int i;
        d = 32'h00000000;
        r = 2'h3;
        @(posedge aclk);
        araddr  <= a;
        arvalid <= 1'b1;
        rready  <= 1'b1;
        for (i = 0; i < 50; i++)
        begin
            @(posedge aclk);
            if (arvalid && arready)
                arvalid <= 1'b0;
            if (rvalid && rready)
            begin
                d = rdata;
                r = rresp;
                rready <= 1'b0;
                return;
            end
        end
        timeout_hit();
    endtask : axi_rd

    // Returns next address and wrap flag in the response's bit order
    function automatic logic [16:0] exp_next(input logic on, input logic y, input logic [15:0] s,
                                             input logic [15:0] e, input logic [15:0] c,
                                             input logic dec, input logic [15:0] st);
        logic [16:0] n;
        logic [15:0] m;
        m = y ? 16'hFFFE : 16'hFFFF;
        s = s & m;
        e = e & m;
        c = c & m;
        n = dec ? {1'b0, c} - {1'b0, st} : {1'b0, c} + {1'b0, st};
        if (on && (n[16] || (dec ? n[15:0] < s : n[15:0] > e)))
            return {(dec ? e : s), 1'b1};
        return {n[15:0] & m, 1'b0};
    endfunction : exp_next

    task automatic agu(input int sp, input logic [3:0] sel, input logic [15:0] c, input logic dec,
                       input logic [15:0] st, input logic on, input logic [15:0] s, input logic [15:0] e);
        circ_pkg::agu_rsp_t r;
        u_agu_core_model.step(sp, sel, c, dec, st);
        r = (sp == 0) ? x_rd_rsp : (sp == 1) ? x_wr_rsp : y_rsp;
        chk(32'(r), 32'(exp_next(on, sp == 2, s, e, c, dec, st)), "address step");
    endtask : agu

    // ************************************************
    // Scenarios
    // ************************************************
    task automatic t_reset;
        axi_rd(`CIRC_CTRL_OFFSET, rd, rs);
        chk(rd, 32'h000000FF, "control reset");
        axi_rd(`CIRC_X_END_OFFSET, rd, rs);
        chk(rd, 32'h0, "bound reset");
        axi_rd(12'h018, rd, rs);
        chk(32'(rs), 32'h2, "unmapped read");
        agu(0, 4'hF, 16'hFFFE, 1'b0, 16'h0002, 1'b0, 16'h0, 16'h0);
        $display("Test reset done");
    endtask : t_reset

    task automatic t_x;
        axi_wr(`CIRC_X_START_OFFSET, 32'h1000, rs);
        axi_wr(`CIRC_X_END_OFFSET, 32'h100E, rs);
        axi_wr(`CIRC_CTRL_OFFSET, 32'h8003, rs);
        chk(32'(rs), 32'h0, "write response");
        axi_rd(`CIRC_X_END_OFFSET, rd, rs);
        chk(rd, 32'h100E, "end readback");
        chk(32'(rs), 32'h0, "read response");
        agu(0, 4'h3, 16'h100E, 1'b0, 16'h0002, 1'b1, 16'h1000, 16'h100E);
        agu(1, 4'h3, 16'h100E, 1'b0, 16'h0002, 1'b1, 16'h1000, 16'h100E);
        agu(0, 4'h3, 16'h1000, 1'b1, 16'h0002, 1'b1, 16'h1000, 16'h100E);
        agu(0, 4'h4, 16'h100E, 1'b0, 16'h0002, 1'b0, 16'h1000, 16'h100E);
        axi_wr(`CIRC_CTRL_OFFSET, 32'h800F, rs);
        agu(0, 4'hF, 16'h100E, 1'b0, 16'h0002, 1'b0, 16'h1000, 16'h100E);
        agu(1, 4'hF, 16'h100E, 1'b0, 16'h0002, 1'b0, 16'h1000, 16'h100E);
        axi_wr(`CIRC_CTRL_OFFSET, 32'h0003, rs);
        agu(0, 4'h3, 16'h100E, 1'b0, 16'h0002, 1'b0, 16'h1000, 16'h100E);
        $display("Test X space done");
    endtask : t_x

    task automatic t_y;
        axi_wr(`CIRC_Y_START_OFFSET, 32'h2000, rs);
        axi_wr(`CIRC_Y_END_OFFSET, 32'h201F, rs);
        axi_wr(`CIRC_CTRL_OFFSET, 32'h4050, rs);
        agu(2, 4'h5, 16'h201F, 1'b0, 16'h0002, 1'b1, 16'h2000, 16'h201F);
        agu(2, 4'h5, 16'h2001, 1'b1, 16'h0002, 1'b1, 16'h2000, 16'h201F);
        agu(2, 4'h5, 16'h2004, 1'b0, 16'h0002, 1'b1, 16'h2000, 16'h201F);
        axi_wr(`CIRC_CTRL_OFFSET, 32'h40F0, rs);
        agu(2, 4'hF, 16'h201E, 1'b0, 16'h0002, 1'b0, 16'h2000, 16'h201F);
        axi_wr(`CIRC_CTRL_OFFSET, 32'h0050, rs);
        agu(2, 4'h5, 16'h201E, 1'b0, 16'h0002, 1'b0, 16'h2000, 16'h201F);
        $display("Test Y space done");
    endtask : t_y

    // Largest buffer: only the 16-bit carry can end it
    task automatic t_len;
        axi_wr(`CIRC_X_START_OFFSET, 32'h0000, rs);
        axi_wr(`CIRC_X_END_OFFSET, 32'hFFFE, rs);
        axi_wr(`CIRC_CTRL_OFFSET, 32'h8001, rs);
        agu(0, 4'h1, 16'h8000, 1'b0, 16'h0002, 1'b1, 16'h0000, 16'hFFFE);
        agu(0, 4'h1, 16'hFFFE, 1'b0, 16'h0002, 1'b1, 16'h0000, 16'hFFFE);
        $display("Test length done");
    endtask : t_len

    // Sticky wrap flags, lane masking and unmapped writes
    task automatic t_status;
        agu(0, 4'h2, 16'h0000, 1'b0, 16'h0002, 1'b0, 16'h0000, 16'hFFFE);
        axi_wr(`CIRC_STATUS_OFFSET, 32'h7, rs);
        axi_rd(`CIRC_STATUS_OFFSET, rd, rs);
        chk(rd, 32'h08, "status cleared");
        agu(0, 4'h1, 16'hFFFE, 1'b0, 16'h0002, 1'b1, 16'h0000, 16'hFFFE);
        agu(0, 4'h2, 16'h0000, 1'b0, 16'h0002, 1'b0, 16'h0000, 16'hFFFE);
        @(posedge aclk);
        wstrb <= 4'h2;
        axi_wr(`CIRC_STATUS_OFFSET, 32'h7, rs);
        axi_rd(`CIRC_STATUS_OFFSET, rd, rs);
        chk(rd, 32'h09, "wrap kept, upper lane ignored");
        @(posedge aclk);
        wstrb <= 4'hF;
        axi_wr(`CIRC_STATUS_OFFSET, 32'h1, rs);
        axi_rd(`CIRC_STATUS_OFFSET, rd, rs);
        chk(rd, 32'h08, "wrap cleared");
        axi_wr(12'h018, 32'h1, rs);
        chk(32'(rs), 32'h2, "unmapped write");
        $display("Test status done");
    endtask : t_status

    // Reset in mid-run restores the disabled state
    task automatic t_mid_reset;
        @(posedge aclk);
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        axi_rd(`CIRC_CTRL_OFFSET, rd, rs);
        chk(rd, 32'h000000FF, "control after reset");
        axi_rd(`CIRC_STATUS_OFFSET, rd, rs);
        chk(rd, 32'h0, "status after reset");
        axi_rd(`CIRC_X_START_OFFSET, rd, rs);
        chk(rd, 32'h0, "start after reset");
        agu(0, 4'h1, 16'hFFFE, 1'b0, 16'h0002, 1'b0, 16'h0000, 16'h0000);
        $display("Test mid-run reset done");
    endtask : t_mid_reset

    initial
    begin
        aresetn = 1'b0;
        awvalid = 1'b0;
        wvalid  = 1'b0;
        bready  = 1'b0;
        arvalid = 1'b0;
        rready  = 1'b0;
        awaddr  = 12'h000;
        araddr  = 12'h000;
        wdata   = 32'h0;
        wstrb   = 4'hF;
        n_fail  = 0;
        total_checks = 0;
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        t_reset();
        t_x();
        t_y();
        t_len();
        t_status();
        t_mid_reset();
        report_and_stop();
    end
endmodule : tb_circ_addr_ctrl

`default_nettype wire
